// ==== rtl/flash_host_pkg.sv ====
// Package for the parallel flash host controller
`default_nettype none
package flash_host_pkg;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 16;
    localparam int CLK_PERIOD_NS = 4;
    // Bus timing in ns, plain defaults; cycles round up
    localparam int T_SETUP_NS = 20;
    localparam int T_ACC_NS = 70;
    localparam int T_CE_NS = 70;
    localparam int T_WP_NS = 40;
    localparam int T_HOLD_NS = 20;
    localparam int T_RP_NS = 500;
    localparam int T_RH_NS = 50;
    localparam logic [7:0] SETUP_CYC =
        8'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] ACC_CYC =
        8'((T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] CE_CYC =
        8'((T_CE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] WP_CYC =
        8'((T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] HOLD_CYC =
        8'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] RP_CYC =
        8'((T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] RH_CYC =
        8'((T_RH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_RST = 19'h0_0000;
    localparam int BYTE_LSB_PIN = 15;

    typedef enum logic [1:0] {
        OP_READ,
        OP_WRITE,
        OP_RESET
    } op_t;

    // Request from user logic
    typedef struct packed {
        op_t               op;
        logic [ADDR_W-1:0] addr;
        logic              byte_lsb;
        logic [DATA_W-1:0] data;
    } req_t;

    // Pins driven toward the flash
    typedef struct packed {
        logic              ce_n;
        logic              oe_n;
        logic              we_n;
        logic              rst_n;
        logic              word_sel;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq_out;
        logic [DATA_W-1:0] dq_oe_n;
    } pins_t;
endpackage
`default_nettype wire

// ==== rtl/flash_pin_sync.sv ====
// Two-stage synchroniser for the data pins
`default_nettype none
module flash_pin_sync
    import flash_host_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              srst,
    input  wire logic              clk_en,
    input  wire logic [DATA_W-1:0] pin_in,
    output logic      [DATA_W-1:0] pin_sync
);
    logic [DATA_W-1:0] meta_r;
    logic [DATA_W-1:0] meta_nxt;
    logic [DATA_W-1:0] sync_r;
    logic [DATA_W-1:0] sync_nxt;

    always_comb begin
        meta_nxt = meta_r;
        sync_nxt = sync_r;
        if (srst) begin
            meta_nxt = DATA_RST;
            sync_nxt = DATA_RST;
        end else if (clk_en) begin
            meta_nxt = pin_in;
            sync_nxt = meta_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        meta_r <= meta_nxt;
        sync_r <= sync_nxt;
    end

    assign pin_sync = sync_r;
endmodule
`default_nettype wire

// ==== rtl/flash_bus_mode_control.sv ====
// Host-side controller driving the parallel flash bus pins
`default_nettype none
module flash_bus_mode_control
    import flash_host_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              srst,
    input  wire logic              clk_en,
    input  wire logic              word_mode,
    input  wire logic              req_valid,
    input  wire req_t              req,
    output logic                   req_ready,
    output logic                   rsp_valid,
    output logic      [DATA_W-1:0] rsp_data,
    input  wire logic [DATA_W-1:0] dq_in,
    output pins_t                  pins
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_READ,
        ST_WRITE,
        ST_HOLD,
        ST_RESET,
        ST_RECOVER
    } state_t;

    state_t            state_r;
    state_t            state_nxt;
    logic [7:0]        cnt_r;
    logic [7:0]        cnt_nxt;
    logic              wide_r;
    logic              wide_nxt;
    req_t              cur_r;
    req_t              cur_nxt;
    pins_t             pins_r;
    pins_t             pins_nxt;
    logic              ready_r;
    logic              ready_nxt;
    logic              rsp_valid_r;
    logic              rsp_valid_nxt;
    logic [DATA_W-1:0] rsp_data_r;
    logic [DATA_W-1:0] rsp_data_nxt;
    logic [DATA_W-1:0] dq_sync;
    logic [DATA_W-1:0] all_float;
    logic [DATA_W-1:0] byte_drive_n;

    flash_pin_sync u_sync (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .clk_en   (clk_en),
        .pin_in   (dq_in),
        .pin_sync (dq_sync)
    );

    assign all_float = '1;
    // Low byte driven as data, pin 15 as address; pins 8..14 left floating
    assign byte_drive_n = 16'h7F00;

    always_comb begin
        state_nxt        = state_r;
        cnt_nxt          = cnt_r;
        wide_nxt         = wide_r;
        cur_nxt          = cur_r;
        pins_nxt         = pins_r;
        ready_nxt        = ready_r;
        rsp_valid_nxt    = rsp_valid_r;
        rsp_data_nxt     = rsp_data_r;
        if (srst) begin
            state_nxt             = ST_RESET;
            cnt_nxt               = RP_CYC;
            wide_nxt              = 1'b1;
            rsp_valid_nxt         = 1'b0;
            cur_nxt               = '0;
            pins_nxt              = '0;
            pins_nxt.ce_n         = 1'b1;
            pins_nxt.oe_n         = 1'b1;
            pins_nxt.we_n         = 1'b1;
            pins_nxt.rst_n        = 1'b0;
            pins_nxt.word_sel     = 1'b1;
            pins_nxt.addr         = ADDR_RST;
            pins_nxt.dq_out       = DATA_RST;
            pins_nxt.dq_oe_n      = all_float;
            ready_nxt             = 1'b0;
            rsp_data_nxt          = DATA_RST;
        end else if (clk_en) begin
            // Pulse ends only on an enabled edge, so a stall keeps it
            rsp_valid_nxt = 1'b0;
            unique case (state_r)
            ST_IDLE: begin
                // Parked deselected: standby, device floats its pins
                pins_nxt.ce_n    = 1'b1;
                pins_nxt.oe_n    = 1'b1;
                pins_nxt.we_n    = 1'b1;
                pins_nxt.dq_oe_n = all_float;
                if (req_valid) begin
                    ready_nxt = 1'b0;
                    cur_nxt   = req;
                    if (req.op == OP_RESET) begin
                        pins_nxt.rst_n = 1'b0;
                        cnt_nxt        = RP_CYC;
                        state_nxt      = ST_RESET;
                    end else begin
                        // Width pin changes on the same edge that selects the chip
                        wide_nxt          = word_mode;
                        pins_nxt.word_sel = word_mode;
                        pins_nxt.addr     = req.addr;
                        pins_nxt.ce_n     = 1'b0;
                        cnt_nxt           = SETUP_CYC;
                        state_nxt         = ST_SETUP;
                    end
                end
            end
            ST_SETUP: begin
                if (cnt_r > 8'h01) begin
                    cnt_nxt = cnt_r - 8'h01;
                end else if (cur_r.op == OP_WRITE) begin
                    // One bus cycle per request; bypass programs take two
                    pins_nxt.we_n   = 1'b0;
                    pins_nxt.dq_out = cur_r.data;
                    if (wide_r) begin
                        pins_nxt.dq_oe_n = '0;
                    end else begin
                        pins_nxt.dq_out[BYTE_LSB_PIN] = cur_r.byte_lsb;
                        pins_nxt.dq_oe_n = byte_drive_n;
                    end
                    cnt_nxt   = WP_CYC;
                    state_nxt = ST_WRITE;
                end else begin
                    pins_nxt.oe_n = 1'b0;
                    pins_nxt.we_n = 1'b1;
                    if (wide_r) begin
                        pins_nxt.dq_oe_n = all_float;
                    end else begin
                        pins_nxt.dq_out = '0;
                        pins_nxt.dq_out[BYTE_LSB_PIN] = cur_r.byte_lsb;
                        pins_nxt.dq_oe_n = ~16'h8000;
                    end
                    // Every access starts deselected, so chip-select
                    // time governs; two more cycles cover the synchroniser
                    cnt_nxt = CE_CYC + 8'h02;
                    state_nxt = ST_READ;
                end
            end
            ST_READ: begin
                if (cnt_r > 8'h01) begin
                    cnt_nxt = cnt_r - 8'h01;
                end else begin
                    // Byte mode: only the low byte is the device's
                    rsp_data_nxt  = wide_r ? dq_sync
                                           : {8'h00, dq_sync[7:0]};
                    rsp_valid_nxt = 1'b1;
                    pins_nxt.oe_n = 1'b1;
                    cnt_nxt       = HOLD_CYC;
                    state_nxt     = ST_HOLD;
                end
            end
            ST_WRITE: begin
                if (cnt_r > 8'h01) begin
                    cnt_nxt = cnt_r - 8'h01;
                end else begin
                    // Device latches data on this rising write strobe
                    pins_nxt.we_n = 1'b1;
                    cnt_nxt       = HOLD_CYC;
                    state_nxt     = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (cnt_r > 8'h01) begin
                    cnt_nxt = cnt_r - 8'h01;
                end else begin
                    // Deselect; embedded operations keep running
                    pins_nxt.ce_n    = 1'b1;
                    pins_nxt.dq_oe_n = all_float;
                    ready_nxt        = 1'b1;
                    state_nxt        = ST_IDLE;
                end
            end
            ST_RESET: begin
                if (cnt_r > 8'h01) begin
                    cnt_nxt = cnt_r - 8'h01;
                end else begin
                    pins_nxt.rst_n = 1'b1;
                    cnt_nxt        = RH_CYC;
                    state_nxt      = ST_RECOVER;
                end
            end
            ST_RECOVER: begin
                if (cnt_r > 8'h01) begin
                    cnt_nxt = cnt_r - 8'h01;
                end else begin
                    ready_nxt = 1'b1;
                    state_nxt = ST_IDLE;
                end
            end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        state_r        <= state_nxt;
        cnt_r          <= cnt_nxt;
        wide_r         <= wide_nxt;
        cur_r          <= cur_nxt;
        pins_r         <= pins_nxt;
        ready_r        <= ready_nxt;
        rsp_valid_r    <= rsp_valid_nxt;
        rsp_data_r     <= rsp_data_nxt;
    end

    assign pins      = pins_r;
    assign req_ready = ready_r;
    assign rsp_valid = rsp_valid_r;
    assign rsp_data  = rsp_data_r;
endmodule
`default_nettype wire

// ==== test/flash_bus_mode_monitor.sv ====
// Bus-shape checker for the flash host controller
`default_nettype none
module flash_bus_mode_monitor
    import flash_host_pkg::*;
(
    input wire logic              sys_clk,
    input wire logic              srst,
    input wire logic              clk_en,
    input wire logic              word_mode,
    input wire logic              req_valid,
    input wire req_t              req,
    input wire logic              req_ready,
    input wire logic              rsp_valid,
    input wire logic [DATA_W-1:0] rsp_data,
    input wire logic [DATA_W-1:0] dq_in,
    input wire pins_t             pins
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    property p_rd_we; !pins.oe_n |-> pins.we_n; endproperty
    a_rd_we: assert property (p_rd_we)
        else $error("strobe low in read");
    property p_rd_ce; !pins.oe_n |-> !pins.ce_n; endproperty
    a_rd_ce: assert property (p_rd_ce)
        else $error("read unselected");
    property p_wr_oe; !pins.we_n |-> pins.oe_n && !pins.ce_n; endproperty
    a_wr_oe: assert property (p_wr_oe)
        else $error("bad write levels");
    property p_byte_flt;
        !pins.ce_n && !pins.word_sel |-> pins.dq_oe_n[14:8] == 7'h7f;
    endproperty
    a_byte_flt: assert property (p_byte_flt)
        else $error("dq14..8 driven");
    property p_byte_lsb; !pins.oe_n && !pins.word_sel |-> !pins.dq_oe_n[15];
    endproperty
    a_byte_lsb: assert property (p_byte_lsb)
        else $error("lsb not driven");
    property p_rd_flt; !pins.oe_n |-> pins.dq_oe_n[7:0] == 8'hff; endproperty
    a_rd_flt: assert property (p_rd_flt)
        else $error("host drives in read");
    property p_acc; rsp_valid |-> $past(pins.ce_n, 18) == 1'b0; endproperty
    a_acc: assert property (p_acc)
        else $error("data before access time");
    property p_pulse; rsp_valid |=> !rsp_valid; endproperty
    a_pulse: assert property (p_pulse)
        else $error("response too long");
    property p_wp; $fell(pins.we_n) |-> !pins.we_n [*8]; endproperty
    a_wp: assert property (p_wp)
        else $error("write pulse short");
    property p_word_wr;
        !pins.we_n && pins.word_sel |-> pins.dq_oe_n == 16'h0000;
    endproperty
    a_word_wr: assert property (p_word_wr)
        else $error("word not driven");
    property p_rst; $fell(pins.rst_n) |-> !pins.rst_n [*8] ##1 pins.ce_n;
    endproperty
    a_rst: assert property (p_rst)
        else $error("reset pulse short");
    c_byte_rd: cover property (rsp_valid && !pins.word_sel);
    c_write: cover property ($rose(pins.we_n));
    c_reset: cover property ($rose(pins.rst_n));
endmodule
bind flash_bus_mode_control flash_bus_mode_monitor u_mon (
    .sys_clk(sys_clk), .srst(srst), .clk_en(clk_en), .word_mode(word_mode),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .dq_in(dq_in), .pins(pins));
`default_nettype wire

// ==== test/flash_dev_model.sv ====
// Behavioural flash die answering on the parallel bus
`default_nettype none
module flash_dev_model
    import flash_host_pkg::*;
#(
    parameter int ACC_DLY = 60
)(
    input  wire pins_t             pins,
    output logic      [DATA_W-1:0] dq_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [int];
    logic [15:0] last = 16'h0000;
    logic [15:0] word_v;
    logic [15:0] dev_v;
    logic [15:0] dev_d;
    logic        drive;
    int          wr_seen = 0;
    // Array read needs no command; reset never touches content
    // Explicit list: a store into the array must refresh the word
    always @(pins.addr or wr_seen) begin
        word_v = mem.exists(int'(pins.addr)) ? mem[int'(pins.addr)]
                 : ({pins.addr[7:0], pins.addr[15:8]} ^ 16'ha5c3);
    end
    // Outputs only when selected, enabled and out of reset
    assign drive = !pins.ce_n && !pins.oe_n
                   && pins.rst_n;
    always @* begin
        if (!drive)
            dev_v = ~last;
        else if (pins.word_sel)
            dev_v = word_v;
        else
            dev_v = {~last[15:8],
                     pins.dq_out[15] ? word_v[15:8] : word_v[7:0]};
    end
    // Slow answer: old pattern shows until access time has run
    assign #(ACC_DLY) dev_d = dev_v;
    // Sleep or not, the complement of the last word shows on the pins
    always @(posedge pins.oe_n) last = dev_d;
    for (genvar i = 0; i < DATA_W; i++) begin : g_wire
        assign dq_in[i] = pins.dq_oe_n[i] ? dev_d[i] : pins.dq_out[i];
    end
    // Committed at strobe rise; a later deselect cannot undo it
    always @(posedge pins.we_n) begin
        if (!pins.ce_n && pins.rst_n) begin
            if (pins.word_sel)
                mem[int'(pins.addr)] = pins.dq_out;
            else if (pins.dq_out[15])
                mem[int'(pins.addr)] = {pins.dq_out[7:0], word_v[7:0]};
            else
                mem[int'(pins.addr)] = {word_v[15:8], pins.dq_out[7:0]};
            wr_seen++;
        end
    end
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the flash host controller
`default_nettype none
module tb_top import flash_host_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 0, srst = 1, clk_en = 1, word_mode = 1;
    logic        req_valid = 0, req_ready, rsp_valid;
    req_t        req = '0;
    logic [15:0] rsp_data, dq_in;
    pins_t       pins;
    int          err_total = 0, checks = 0;
    logic [15:0] expq[$];
    logic [15:0] shadow[int];
    logic [31:0] seed = 32'he66e;
    logic [31:0] r;

    initial forever #2 sys_clk = ~sys_clk;
    flash_bus_mode_control flash_bus_mode_control_inst (.sys_clk(sys_clk),
        .srst(srst), .clk_en(clk_en), .word_mode(word_mode),
        .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .dq_in(dq_in),
        .pins(pins));
    flash_dev_model flash_dev_model_inst (.pins(pins), .dq_in(dq_in));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [15:0] cur(logic [18:0] a);
        return shadow.exists(int'(a)) ? shadow[int'(a)]
               : ({a[7:0], a[15:8]} ^ 16'ha5c3);
    endfunction
    task automatic cmp_rsp(logic [15:0] got, logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic do_req(op_t op, logic [18:0] a, logic lsb, logic [15:0] d,
                          logic wm);
        int          n;
        logic [15:0] w;
        n = 0;
        while (req_ready !== 1'b1 && n < 2000) begin
            @(posedge sys_clk);
            #1 n++;
        end
        if (n >= 2000)
            err_total++;
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req <= '{op: op, addr: a, byte_lsb: lsb, data: d};
        word_mode <= wm;
        @(posedge sys_clk);
        req_valid <= 1'b0;
        w = cur(a);
        if (op == OP_READ)
            expq.push_back(wm ? w : {8'h00, lsb ? w[15:8] : w[7:0]});
        if (op == OP_WRITE)
            shadow[int'(a)] = wm ? d : lsb ? {d[7:0], w[7:0]} : {w[15:8], d[7:0]};
        #1;
    endtask

    // Oldest expected read result meets each response pulse
    always @(posedge sys_clk) begin
        if (!srst && rsp_valid === 1'b1) begin
            if (expq.size() == 0)
                cmp_rsp(rsp_data, 16'hxxxx);
            else
                cmp_rsp(rsp_data, expq.pop_front());
        end
    end

    initial begin
        #200000;
        err_total++;
        stop_test();
    end

    initial begin
        repeat (8) @(posedge sys_clk);
        srst <= 1'b0;
        do_req(OP_READ, 19'h0_0123, 1'b0, 16'h0000, 1'b1);
        do_req(OP_READ, 19'h0_0123, 1'b0, 16'h0000, 1'b0);
        do_req(OP_READ, 19'h0_0123, 1'b1, 16'h0000, 1'b0);
        do_req(OP_WRITE, 19'h7_ffff, 1'b0, 16'hbeef, 1'b1);
        do_req(OP_READ, 19'h7_ffff, 1'b0, 16'h0000, 1'b1);
        do_req(OP_WRITE, 19'h0_0010, 1'b1, 16'h005a, 1'b0);
        do_req(OP_READ, 19'h0_0010, 1'b0, 16'h0000, 1'b1);
        // Bypass program: command cycle then data cycle, read back
        do_req(OP_WRITE, 19'h0_0555, 1'b0, 16'h00a0, 1'b1);
        do_req(OP_WRITE, 19'h0_0020, 1'b0, 16'h1234, 1'b1);
        do_req(OP_READ, 19'h0_0020, 1'b0, 16'h0000, 1'b1);
        do_req(OP_WRITE, 19'h4_0000, 1'b0, 16'h0030, 1'b1);
        do_req(OP_READ, 19'h4_0000, 1'b0, 16'h0000, 1'b0);
        do_req(OP_READ, 19'h0_0001, 1'b0, 16'h0000, 1'b0);
        do_req(OP_RESET, 19'h0_0000, 1'b0, 16'h0000, 1'b1);
        do_req(OP_READ, 19'h7_ffff, 1'b1, 16'h0000, 1'b0);
        // Small address set so random writes are read back
        repeat (24) begin
            r = xs();
            do_req(r[0] ? OP_READ : OP_WRITE, 19'(r[3:1]), r[5], r[31:16],
                   r[4]);
        end
        repeat (200) begin
            if (expq.size() != 0)
                @(posedge sys_clk);
        end
        if (expq.size() != 0)
            err_total++;
        stop_test();
    end
endmodule
`default_nettype wire
